// file: core/tsec_top.sv
// Two-stage event controller: core stage, AXI4-Lite registers and sequencer port.
//
// Behaviour
// - Fixed priority, 0 highest: emu, reset, NMI, exception, reserved, hwerr, timer, 7-15.
// - Nesting lets several service routines be active, interrupted only by higher ones.
// - Among competing events the higher priority one is serviced first.
// - Five event classes: emulation, reset, non-maskable, exception, interrupt.
// - Emulation event puts the processor into emulation mode under JTAG control.
// - Reset event puts the whole processor into its reset state.
// - Watchdog expiry or external NMI input raises the non-maskable event.
// - Exceptions are synchronous to program flow, taken before the instruction completes.
// - Interrupts come asynchronously from pins, timers, peripherals and a software raise.
// - Each class has its own return-address register and return-from-event resume.
// - Taking an event saves processor state on the supervisor stack.
// - Peripheral requests enter the system stage and route onto general-purpose levels.
// - Core stage has nine general-purpose levels 7 to 15 besides dedicated events.
// - Default source-to-level mapping after reset; assignment writes change it.
// - Core stage holds 16-bit latch, mask and pending registers.
// - Latch bit sets on event, clears on acceptance; writable only while masked.
// - Set mask bit lets its event be serviced; clear mask bit blocks it, except at levels 0 to 3, which cannot be masked.
// - Pending bit is set while its event is active or nested; hardware updates it. Accepting the reset event clears all pending bits, its own included.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module tsec_top
	import tsec_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// AXI4-Lite register port
	input  wire tsec_axi_in_t  axi_in,
	output tsec_axi_out_t      axi_out,
	// Asynchronous event inputs
	input  wire logic [`TSEC_NUM_SRC-1:0] periph_irq,
	input  wire logic        nmi_pin,
	input  wire logic        emu_req,
	// Same-clock event inputs
	input  wire logic        wdog_fire,
	input  wire logic        reset_req,
	input  wire logic        exc_req,
	input  wire logic        hw_err,
	input  wire logic        timer_irq,
	// Sequencer dispatch
	input  wire logic [31:0] pc_in,
	input  wire logic        disp_ready,
	output logic             disp_valid,
	output logic      [3:0]  disp_level,
	output logic             state_save,
	output logic             proc_reset,
	output logic             emu_mode,
	// Sequencer return from event
	input  wire logic        ret_valid,
	input  wire tsec_class_t ret_class,
	output logic             resume_valid,
	output logic      [31:0] resume_addr
);

	// ****************************************************************
	// State and helpers
	// ****************************************************************
	tsec_state_t st;
	tsec_state_t next_st;
	logic [`TSEC_NUM_GP-1:0] gp_req;

	localparam tsec_state_t RESET_ST = '{
		fsm:         TSEC_IDLE,
		mask:        `TSEC_RST_MASK,
		gp_en:       `TSEC_RST_CTRL,
		assign_regs: {`TSEC_RST_ASSIGN3, `TSEC_RST_ASSIGN2,
		              `TSEC_RST_ASSIGN1, `TSEC_RST_ASSIGN0},
		bresp:       `TSEC_RESP_OKAY,
		rresp:       `TSEC_RESP_OKAY,
		default:     '0
	};

	// Returns {found, index} of the lowest set bit, the highest priority.
	function automatic logic [4:0] first_set(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, i[3:0]};
			end
		end
		return r;
	endfunction : first_set

	function automatic tsec_class_t class_of(input logic [3:0] lvl);
		tsec_class_t c;
		case (lvl)
			`TSEC_LVL_EMU: c = TSEC_CLS_EMU;
			`TSEC_LVL_RST: c = TSEC_CLS_RST;
			`TSEC_LVL_NMI: c = TSEC_CLS_NMI;
			`TSEC_LVL_EXC: c = TSEC_CLS_EXC;
			default:       c = TSEC_CLS_INT;
		endcase
		return c;
	endfunction : class_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ****************************************************************
	// System stage
	// ****************************************************************
	tsec_sys_stage u_sys (
		.src_req     (st.src_s2),
		.assign_regs (st.assign_regs),
		.gp_req      (gp_req)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [15:0] emask;
		logic [15:0] ready_ev;
		logic [15:0] set_ev;
		logic [15:0] clr_ev;
		logic [4:0]  best;
		logic [4:0]  top_pend;
		logic        have_aw;
		logic        have_w;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic [31:0] rd;
		logic        rerr;
		logic        werr;
		emask    = 16'h0000;
		ready_ev = 16'h0000;
		set_ev   = 16'h0000;
		clr_ev   = 16'h0000;
		best     = 5'h00;
		top_pend = 5'h00;
		have_aw  = 1'b0;
		have_w   = 1'b0;
		wa       = 8'h00;
		wd       = 32'h00000000;
		ws       = 4'h0;
		rd       = 32'h00000000;
		rerr     = 1'b0;
		werr     = 1'b0;
		next_st  = st;

		next_st.src_s1       = periph_irq;
		next_st.src_s2       = st.src_s1;
		next_st.nmi_s1       = nmi_pin;
		next_st.nmi_s2       = st.nmi_s1;
		next_st.nmi_d        = st.nmi_s2;
		next_st.emu_s1       = emu_req;
		next_st.emu_s2       = st.emu_s1;
		next_st.emu_d        = st.emu_s2;
		next_st.state_save   = 1'b0;
		next_st.proc_reset   = 1'b0;
		next_st.resume_valid = 1'b0;

		// Event sources into the latch.
		set_ev[`TSEC_LVL_EMU] = st.emu_s2 && !st.emu_d;
		set_ev[`TSEC_LVL_RST] = reset_req;
		set_ev[`TSEC_LVL_NMI] = (st.nmi_s2 && !st.nmi_d) || wdog_fire;
		set_ev[`TSEC_LVL_EXC] = exc_req;
		set_ev[`TSEC_LVL_HWE] = hw_err;
		set_ev[`TSEC_LVL_TMR] = timer_irq;
		set_ev[15:7]          = gp_req;

		// Emulation, reset, NMI and exception cannot be masked.
		emask    = (st.mask | `TSEC_FORCED_MASK) & `TSEC_VALID_BITS;
		ready_ev = st.latch & emask;
		if (!st.gp_en) begin
			ready_ev = ready_ev & ~`TSEC_GP_BITS;
		end
		best     = first_set(ready_ev);
		top_pend = first_set(st.pending);

		// AXI4-Lite write: address and data in either order.
		have_aw = st.aw_got || (axi_in.awvalid && !st.bvalid);
		have_w  = st.w_got || (axi_in.wvalid && !st.bvalid);
		wa      = st.aw_got ? st.awaddr : axi_in.awaddr;
		wd      = st.w_got ? st.wdata : axi_in.wdata;
		ws      = st.w_got ? st.wstrb : axi_in.wstrb;
		if (!st.aw_got && axi_in.awvalid && !st.bvalid) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = axi_in.awaddr;
		end
		if (!st.w_got && axi_in.wvalid && !st.bvalid) begin
			next_st.w_got = 1'b1;
			next_st.wdata = axi_in.wdata;
			next_st.wstrb = axi_in.wstrb;
		end
		if (have_aw && have_w && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			case ({wa[7:2], 2'b00})
				`TSEC_OFS_LATCH: begin
					next_st.latch = ((st.latch & emask) |
						(16'(merge(32'(st.latch), wd, ws)) & ~emask)) & `TSEC_VALID_BITS;
				end
				`TSEC_OFS_MASK: begin
					next_st.mask = 16'(merge(32'(st.mask), wd, ws)) & `TSEC_VALID_BITS;
				end
				`TSEC_OFS_PEND: begin
				end
				`TSEC_OFS_CTRL: begin
					next_st.gp_en = ws[0] ? wd[`TSEC_CTRL_GPEN] : st.gp_en;
				end
				`TSEC_OFS_RAISE: begin
					set_ev = set_ev | (16'(merge(32'h00000000, wd, ws)) & `TSEC_GP_BITS);
				end
				`TSEC_OFS_ASSIGN0: next_st.assign_regs[0] = merge(st.assign_regs[0], wd, ws);
				`TSEC_OFS_ASSIGN1: next_st.assign_regs[1] = merge(st.assign_regs[1], wd, ws);
				`TSEC_OFS_ASSIGN2: next_st.assign_regs[2] = merge(st.assign_regs[2], wd, ws);
				`TSEC_OFS_ASSIGN3: next_st.assign_regs[3] = merge(st.assign_regs[3], wd, ws);
				default: werr = 1'b1;
			endcase
			next_st.bresp = werr ? `TSEC_RESP_SLVERR : `TSEC_RESP_OKAY;
		end
		if (st.bvalid && axi_in.bready) begin
			next_st.bvalid = 1'b0;
		end

		// AXI4-Lite read.
		if (axi_in.arvalid && !st.rvalid) begin
			case ({axi_in.araddr[7:2], 2'b00})
				`TSEC_OFS_LATCH:   rd = 32'(st.latch);
				`TSEC_OFS_MASK:    rd = 32'(emask);
				`TSEC_OFS_PEND:    rd = 32'(st.pending);
				`TSEC_OFS_CTRL:    rd = 32'(st.gp_en);
				`TSEC_OFS_RAISE:   rd = 32'h00000000;
				`TSEC_OFS_ASSIGN0: rd = st.assign_regs[0];
				`TSEC_OFS_ASSIGN1: rd = st.assign_regs[1];
				`TSEC_OFS_ASSIGN2: rd = st.assign_regs[2];
				`TSEC_OFS_ASSIGN3: rd = st.assign_regs[3];
				default:           rerr = 1'b1;
			endcase
			next_st.rvalid = 1'b1;
			next_st.rdata  = rd;
			next_st.rresp  = rerr ? `TSEC_RESP_SLVERR : `TSEC_RESP_OKAY;
		end else if (st.rvalid && axi_in.rready) begin
			next_st.rvalid = 1'b0;
		end

		// Dispatch towards the sequencer.
		case (st.fsm)
			TSEC_IDLE: begin
				if (best[4] && (!top_pend[4] || best[3:0] < top_pend[3:0])) begin
					next_st.disp_level = best[3:0];
					next_st.fsm        = TSEC_OFFER;
				end
			end
			TSEC_OFFER: begin
				if (!ready_ev[st.disp_level]) begin
					next_st.fsm = TSEC_IDLE;
				end else if (disp_ready) begin
					clr_ev[st.disp_level]          = 1'b1;
					next_st.pending[st.disp_level] = 1'b1;
					next_st.ret_addr[class_of(st.disp_level)] = pc_in;
					next_st.state_save = 1'b1;
					next_st.fsm        = TSEC_SAVE;
					if (st.disp_level == `TSEC_LVL_RST) begin
						next_st.proc_reset = 1'b1;
						next_st.pending    = 16'h0000;
						next_st.mask       = `TSEC_RST_MASK;
						next_st.gp_en      = `TSEC_RST_CTRL;
					end
				end
			end
			TSEC_SAVE: begin
				next_st.fsm = TSEC_IDLE;
			end
			default: begin
				next_st.fsm = TSEC_IDLE;
			end
		endcase

		// Return from event ends the innermost, highest-priority active event.
		if (ret_valid && top_pend[4]) begin
			next_st.pending[top_pend[3:0]] = 1'b0;
			next_st.resume_addr  = st.ret_addr[ret_class];
			next_st.resume_valid = 1'b1;
		end

		// A new event in the cycle of its clear keeps the bit set.
		next_st.latch = ((next_st.latch & ~clr_ev) | set_ev) & `TSEC_VALID_BITS;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= RESET_ST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign axi_out.awready = !st.aw_got && !st.bvalid;
	assign axi_out.wready  = !st.w_got && !st.bvalid;
	assign axi_out.bvalid  = st.bvalid;
	assign axi_out.bresp   = st.bresp;
	assign axi_out.arready = !st.rvalid;
	assign axi_out.rvalid  = st.rvalid;
	assign axi_out.rdata   = st.rdata;
	assign axi_out.rresp   = st.rresp;

	assign disp_valid   = (st.fsm == TSEC_OFFER);
	assign disp_level   = st.disp_level;
	assign state_save   = st.state_save;
	assign proc_reset   = st.proc_reset;
	assign emu_mode     = st.pending[`TSEC_LVL_EMU];
	assign resume_valid = st.resume_valid;
	assign resume_addr  = st.resume_addr;

endmodule : tsec_top

// file: core/tsec_defines.svh
// Constants of the two-stage event controller: offsets, field positions and reset values.
`ifndef TSEC_DEFINES_SVH
`define TSEC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TSEC_OFS_LATCH   8'h00
`define TSEC_OFS_MASK    8'h04
`define TSEC_OFS_PEND    8'h08
`define TSEC_OFS_CTRL    8'h0C
`define TSEC_OFS_RAISE   8'h10
`define TSEC_OFS_ASSIGN0 8'h20
`define TSEC_OFS_ASSIGN1 8'h24
`define TSEC_OFS_ASSIGN2 8'h28
`define TSEC_OFS_ASSIGN3 8'h2C

// ****************************************************************
// Sizes and field positions
// ****************************************************************
`define TSEC_NUM_SRC     32
`define TSEC_NUM_GP      9
`define TSEC_NUM_ASSIGN  4
`define TSEC_FLD_PER_REG 8
`define TSEC_FLD_W       4
`define TSEC_CTRL_GPEN   0

// ****************************************************************
// Event levels, priority 0 highest
// ****************************************************************
`define TSEC_LVL_EMU     4'h0
`define TSEC_LVL_RST     4'h1
`define TSEC_LVL_NMI     4'h2
`define TSEC_LVL_EXC     4'h3
`define TSEC_LVL_RSVD    4'h4
`define TSEC_LVL_HWE     4'h5
`define TSEC_LVL_TMR     4'h6
`define TSEC_LVL_GP0     4'h7
`define TSEC_GP_BITS     16'hFF80

// ****************************************************************
// Reset values and fixed bit masks
// ****************************************************************
`define TSEC_RST_MASK    16'h0000
`define TSEC_FORCED_MASK 16'h000F
`define TSEC_VALID_BITS  16'hFFEF
`define TSEC_RST_ASSIGN0 32'h00000000
`define TSEC_RST_ASSIGN1 32'h11000000
`define TSEC_RST_ASSIGN2 32'h33332222
`define TSEC_RST_ASSIGN3 32'h44444433
`define TSEC_RST_CTRL    1'h0

// ****************************************************************
// Bus responses
// ****************************************************************
`define TSEC_RESP_OKAY   2'h0
`define TSEC_RESP_SLVERR 2'h2

`endif

// file: core/tsec_pkg.sv
// Types shared by the event controller files.
`include "tsec_defines.svh"

package tsec_pkg;

	typedef enum logic [1:0] {
		TSEC_IDLE  = 2'h0,
		TSEC_OFFER = 2'h1,
		TSEC_SAVE  = 2'h3
	} tsec_fsm_t;

	typedef enum logic [2:0] {
		TSEC_CLS_EMU = 3'h0,
		TSEC_CLS_RST = 3'h1,
		TSEC_CLS_NMI = 3'h2,
		TSEC_CLS_EXC = 3'h3,
		TSEC_CLS_INT = 3'h4
	} tsec_class_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} tsec_axi_in_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tsec_axi_out_t;

	typedef struct packed {
		tsec_fsm_t                      fsm;
		logic [`TSEC_NUM_SRC-1:0]       src_s1;
		logic [`TSEC_NUM_SRC-1:0]       src_s2;
		logic                           nmi_s1;
		logic                           nmi_s2;
		logic                           nmi_d;
		logic                           emu_s1;
		logic                           emu_s2;
		logic                           emu_d;
		logic [15:0]                    latch;
		logic [15:0]                    mask;
		logic [15:0]                    pending;
		logic                           gp_en;
		logic [`TSEC_NUM_ASSIGN-1:0][31:0] assign_regs;
		logic [4:0][31:0]               ret_addr;
		logic [3:0]                     disp_level;
		logic                           state_save;
		logic                           proc_reset;
		logic                           resume_valid;
		logic [31:0]                    resume_addr;
		logic                           aw_got;
		logic [7:0]                     awaddr;
		logic                           w_got;
		logic [31:0]                    wdata;
		logic [3:0]                     wstrb;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           rvalid;
		logic [31:0]                    rdata;
		logic [1:0]                     rresp;
	} tsec_state_t;

endpackage : tsec_pkg

// file: core/tsec_sys_stage.sv
// System stage: routes peripheral requests onto the general-purpose levels.
`timescale 1ns/1ns
module tsec_sys_stage
	import tsec_pkg::*;
(
	// Synchronised peripheral requests
	input  wire logic [`TSEC_NUM_SRC-1:0]          src_req,
	// Assignment registers, one nibble per source
	input  wire logic [`TSEC_NUM_ASSIGN-1:0][31:0] assign_regs,
	// Requests per general-purpose level
	output logic      [`TSEC_NUM_GP-1:0]           gp_req
);

	logic [`TSEC_NUM_SRC-1:0][`TSEC_FLD_W-1:0] fld;

	assign fld = assign_regs;

	// Each level is the OR of every source whose field names it.
	for (genvar g = 0; g < `TSEC_NUM_GP; g++) begin : g_lvl
		logic [`TSEC_NUM_SRC-1:0] hit;
		for (genvar s = 0; s < `TSEC_NUM_SRC; s++) begin : g_src
			assign hit[s] = src_req[s] && (fld[s] == (`TSEC_FLD_W)'(g));
		end
		assign gp_req[g] = |hit;
	end

endmodule : tsec_sys_stage

// file: test/tsec_chk_sva.sv
// Concurrent checks on the ports of the event controller.
`timescale 1ns/1ns
module tsec_chk
	import tsec_pkg::*;
(
	// Clock, reset and enable
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          ce,
	// Register bus
	input wire tsec_axi_in_t  axi_in,
	input wire tsec_axi_out_t axi_out,
	// Dispatch and return
	input wire logic          disp_ready,
	input wire logic          disp_valid,
	input wire logic [3:0]    disp_level,
	input wire logic          state_save,
	input wire logic          proc_reset,
	input wire logic          emu_mode,
	input wire logic          ret_valid,
	input wire logic          resume_valid
);
	// ********************************
	// Properties
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_answer: assert property (
		ce && axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready
		|=> axi_out.bvalid) else $error("write response missing");
	a_read_answer: assert property (
		ce && axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
		else $error("read response missing");
	a_read_holds: assert property (
		axi_out.rvalid && !axi_in.rready |=> axi_out.rvalid && $stable(axi_out.rdata))
		else $error("read data dropped early");
	a_offer_holds: assert property (
		disp_valid && !disp_ready |=> !disp_valid || $stable(disp_level))
		else $error("offered level changed");
	a_accept_saves: assert property (
		ce && disp_valid && disp_ready |=> state_save ##1 !state_save)
		else $error("state save pulse wrong");
	a_reset_pulse: assert property (
		ce && disp_valid && disp_ready |=> proc_reset == ($past(disp_level) == 4'h1))
		else $error("processor reset pulse wrong");
	a_offer_gap: assert property (
		state_save |-> !disp_valid ##1 !disp_valid) else $error("offers too close");
	a_emu_enter: assert property (
		ce && disp_valid && disp_ready && disp_level == 4'h0 |-> ##[1:2] emu_mode)
		else $error("emulation mode not entered");
	a_emu_blocks: assert property (
		emu_mode && !$past(ret_valid) && !$past(ret_valid, 2) |-> !disp_valid)
		else $error("offer during emulation");
	a_level_legal: assert property (
		disp_valid |-> disp_level != 4'h4) else $error("reserved level offered");
	a_resume_cause: assert property (
		resume_valid |-> $past(ret_valid)) else $error("resume without return");
endmodule : tsec_chk

bind tsec_top tsec_chk u_chk (.aclk, .aresetn, .ce, .axi_in, .axi_out, .disp_ready,
	.disp_valid, .disp_level, .state_save, .proc_reset, .emu_mode, .ret_valid,
	.resume_valid);

// file: test/tsec_seq_model.sv
// Instruction sequencer model: accepts offers and runs a program counter.
`timescale 1ns/1ns
module tsec_seq_model (
	// Clock, reset and stall control
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  hold,
	// Dispatch side
	output logic       disp_ready,
	output logic[31:0] pc_in
);
	// Ready is registered, so a stall shows one cycle after hold rises.
	always @(posedge aclk) begin
		if (!aresetn) begin
			disp_ready <= 1'b0;
			pc_in      <= 32'h00001000;
		end else begin
			disp_ready <= !hold;
			pc_in      <= pc_in + 32'h4;
		end
	end
endmodule : tsec_seq_model

// file: test/tsec_top_tb.sv
// Self-checking testbench of the event controller.
`timescale 1ns/1ns
module tsec_top_tb;
	import tsec_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [1:0]  resp;
	} tsec_row_t;
	localparam logic [1:0] rok = `TSEC_RESP_OKAY;
	localparam logic [1:0] rerr = `TSEC_RESP_SLVERR;
	localparam int NROW = 19;
	logic          aclk = 0, aresetn = 0, ce = 1, nmi_pin = 0, emu_req = 0, hold = 0;
	logic [4:0]    ev = '0;
	logic [31:0]   periph_irq = '0, pc_in, resume_addr, pc, pc6;
	tsec_axi_in_t  axi_in = '0;
	tsec_axi_out_t axi_out;
	logic          disp_ready, disp_valid, state_save, proc_reset, emu_mode;
	logic          ret_valid = 0, resume_valid;
	logic [3:0]    disp_level;
	tsec_class_t   ret_class = TSEC_CLS_EMU;
	int            error_cnt = 0, n_checks = 0, cyc = 0;
	logic [3:0]    lv [4] = '{4'h2, 4'h3, 4'h5, 4'h6};
	tsec_class_t   cl [4] = '{TSEC_CLS_NMI, TSEC_CLS_EXC, TSEC_CLS_INT, TSEC_CLS_INT};
	int            src [4] = '{0, 14, 16, 31};
	logic [3:0]    glv [4] = '{4'h7, 4'h8, 4'h9, 4'hB};
	tsec_row_t     rows [NROW] = '{
		'{1'b0, `TSEC_OFS_LATCH, 32'h0, rok}, '{1'b0, `TSEC_OFS_MASK, 32'hF, rok},
		'{1'b0, `TSEC_OFS_PEND, 32'h0, rok}, '{1'b0, `TSEC_OFS_CTRL, 32'h0, rok},
		'{1'b0, `TSEC_OFS_ASSIGN0, `TSEC_RST_ASSIGN0, rok},
		'{1'b0, `TSEC_OFS_ASSIGN1, `TSEC_RST_ASSIGN1, rok},
		'{1'b0, `TSEC_OFS_ASSIGN2, `TSEC_RST_ASSIGN2, rok},
		'{1'b0, `TSEC_OFS_ASSIGN3, `TSEC_RST_ASSIGN3, rok},
		'{1'b1, `TSEC_OFS_PEND, 32'hFFFF, rok}, '{1'b0, `TSEC_OFS_PEND, 32'h0, rok},
		'{1'b1, 8'h40, 32'h0, rerr}, '{1'b0, 8'h40, 32'h0, rerr},
		'{1'b1, `TSEC_OFS_LATCH, 32'h180, rok}, '{1'b0, `TSEC_OFS_LATCH, 32'h180, rok},
		'{1'b1, `TSEC_OFS_MASK, 32'h80, rok}, '{1'b1, `TSEC_OFS_LATCH, 32'h0, rok},
		'{1'b0, `TSEC_OFS_LATCH, 32'h80, rok}, '{1'b0, `TSEC_OFS_MASK, 32'h8F, rok},
		'{1'b0, `TSEC_OFS_RAISE, 32'h0, rok}};

	always #25 aclk = ~aclk;

	tsec_top u_dut (.aclk, .aresetn, .ce, .axi_in, .axi_out, .periph_irq, .nmi_pin,
		.emu_req, .wdog_fire(ev[3]), .reset_req(ev[4]), .exc_req(ev[2]), .hw_err(ev[1]),
		.timer_irq(ev[0]), .pc_in, .disp_ready, .disp_valid, .disp_level, .state_save,
		.proc_reset, .emu_mode, .ret_valid, .ret_class, .resume_valid, .resume_addr);
	tsec_seq_model u_seq (.aclk, .aresetn, .hold, .disp_ready, .pc_in);

	// ********************************
	// Tasks
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic note(input string s);
		$display("Test %s finished", s);
	endtask : note

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_p, w_p, aw, w;
		int   n;
		aw_p = 1;
		w_p = 1;
		n = 0;
		@(posedge aclk);
		axi_in.awvalid <= 1'b1;
		axi_in.awaddr  <= a;
		axi_in.wvalid  <= 1'b1;
		axi_in.wdata   <= d;
		axi_in.wstrb   <= 4'hF;
		axi_in.bready  <= 1'b1;
		while ((aw_p || w_p) && n < 100) begin
			@(negedge aclk);
			aw = aw_p && axi_out.awready === 1'b1;
			w = w_p && axi_out.wready === 1'b1;
			n++;
			@(posedge aclk);
			if (aw) begin
				axi_in.awvalid <= 1'b0;
				aw_p = 0;
			end
			if (w) begin
				axi_in.wvalid <= 1'b0;
				w_p = 0;
			end
		end
		do begin
			@(negedge aclk);
			n++;
		end while (axi_out.bvalid !== 1'b1 && n < 200);
		check(axi_out.bresp, r);
		@(posedge aclk);
		axi_in.bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		axi_in.arvalid <= 1'b1;
		axi_in.araddr  <= a;
		axi_in.rready  <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (axi_out.arready !== 1'b1 && n < 100);
		@(posedge aclk);
		axi_in.arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			n++;
		end while (axi_out.rvalid !== 1'b1 && n < 200);
		check(axi_out.rresp, r);
		if (r == rok) check(axi_out.rdata, d);
		@(posedge aclk);
		axi_in.rready <= 1'b0;
	endtask : axi_rd

	task automatic pulse(input logic [4:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= '0;
	endtask : pulse

	task automatic firq(input int k);
		@(posedge aclk);
		periph_irq <= 32'h1 << k;
		@(posedge aclk);
		periph_irq <= '0;
	endtask : firq

	task automatic take(input logic [3:0] lvl, output logic [31:0] p);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!(disp_valid === 1'b1 && disp_ready === 1'b1) && n < 200);
		check(disp_level, lvl);
		p = pc_in;
		@(negedge aclk);
		check(state_save, 1'b1);
		check(proc_reset, lvl == 4'h1);
	endtask : take

	task automatic ret(input tsec_class_t c, input logic [31:0] p);
		@(posedge aclk);
		ret_valid <= 1'b1;
		ret_class <= c;
		@(posedge aclk);
		ret_valid <= 1'b0;
		@(negedge aclk);
		check(resume_valid, 1'b1);
		check(resume_addr, p);
	endtask : ret

	// ********************************
	// Sequence
	// ********************************
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < NROW; i++) begin
			if (rows[i].wr) axi_wr(rows[i].addr, rows[i].data, rows[i].resp);
			else axi_rd(rows[i].addr, rows[i].data, rows[i].resp);
		end
		note("registers");
		axi_wr(`TSEC_OFS_MASK, 32'hFFE0, rok);
		axi_wr(`TSEC_OFS_CTRL, 32'h1, rok);
		take(4'h7, pc);
		ret(TSEC_CLS_INT, pc);
		hold <= 1'b1;
		pulse(5'h0F);
		repeat (6) @(posedge aclk);
		hold <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			take(lv[i], pc);
			ret(cl[i], pc);
		end
		note("priority");
		pulse(5'h01);
		take(4'h6, pc6);
		pulse(5'h04);
		take(4'h3, pc);
		axi_rd(`TSEC_OFS_PEND, 32'h48, rok);
		ret(TSEC_CLS_EXC, pc);
		ret(TSEC_CLS_INT, pc6);
		note("nesting");
		for (int i = 0; i < 4; i++) begin
			firq(src[i]);
			take(glv[i], pc);
			ret(TSEC_CLS_INT, pc);
		end
		axi_wr(`TSEC_OFS_ASSIGN0, 32'h5, rok);
		firq(0);
		take(4'hC, pc);
		ret(TSEC_CLS_INT, pc);
		axi_wr(`TSEC_OFS_RAISE, 32'h8000, rok);
		take(4'hF, pc);
		ret(TSEC_CLS_INT, pc);
		note("routing");
		@(posedge aclk);
		emu_req <= 1'b1;
		take(4'h0, pc);
		@(negedge aclk);
		check(emu_mode, 1'b1);
		ret(TSEC_CLS_EMU, pc);
		repeat (3) @(negedge aclk);
		check(emu_mode, 1'b0);
		@(posedge aclk);
		emu_req <= 1'b0;
		nmi_pin <= 1'b1;
		take(4'h2, pc);
		ret(TSEC_CLS_NMI, pc);
		@(posedge aclk);
		nmi_pin <= 1'b0;
		note("emulation and nmi");
		pulse(5'h10);
		take(4'h1, pc);
		axi_rd(`TSEC_OFS_MASK, 32'hF, rok);
		axi_rd(`TSEC_OFS_CTRL, 32'h0, rok);
		pulse(5'h02);
		repeat (8) begin
			@(negedge aclk);
			check(disp_valid, 1'b0);
		end
		axi_wr(`TSEC_OFS_MASK, 32'h20, rok);
		take(4'h5, pc);
		ret(TSEC_CLS_INT, pc);
		axi_wr(`TSEC_OFS_LATCH, 32'h100, rok);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		ce      <= 1'b0;
		pulse(5'h02);
		ce      <= 1'b1;
		axi_rd(`TSEC_OFS_LATCH, 32'h0, rok);
		axi_rd(`TSEC_OFS_MASK, 32'hF, rok);
		note("reset");
		complete_run();
	end
endmodule : tsec_top_tb
